// File: t1irq_top.sv
// Framer interrupt masking, pending logic and line receiver configuration word
// Functional notes
// - Framing bit error interrupts only while in terminal frame sync and unmasked.
// - Each local CRC-6 failure interrupts when its mask bit is set.
// - Received yellow alarm detection interrupts when its mask bit is set.
// - Reframe ending at a new alignment interrupts when unmasked.
// - Line code violations, except B8ZS substitution ones, interrupt when unmasked.
// - PRBS checker bit errors interrupt when unmasked.
// - Excess consecutive zeros interrupt when the pulse density bit is set.
// - Eight counter wraps from all ones to zero interrupt per mask bit.
// - Each HDLC unit interrupts only with its own mask and unmasked event.
// - Loop up or down code held 48 ms interrupts when unmasked.
// - One second status rising edge interrupts when unmasked.
// - Five second status rising edge interrupts when unmasked.
// - New bit message seen 8 of last 10 positions interrupts.
// - Signaling pattern change interrupts, optionally debounced first.
// - Framer-only mode uses NRZ on A in and B out when the NRZ bit is set, else dual rail.
// - Termination bit switches the internal receive resistor across tip and ring.
// - Equalizer field 00 is manual, 11 automatic; 01 and 10 not written.
// - Manual equalizer mode forces the level chosen by the select field.
// - Error, wrap and link mask bits: one enables its source, zero blocks it; the alarm mask gates nothing.
// - Acknowledge clears all pending interrupts and releases the request, unless an unmasked event arrives in the same cycle.
// - Suspend holds the request released and ignores all sources.
`timescale 1ns/10ps
`include "t1irq_defines.svh"
module t1irq_top
    import t1irq_pkg::*;
#(
    parameter int unsigned LOOP_CYCLES     = `T1IRQ_LOOP_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = `T1IRQ_SIG_DEBOUNCE,
    parameter int          CNT_W           = 8
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rstn,
    // Microport register access
    input  wire logic                        bus_cs_n,
    input  wire logic                        bus_rd,
    input  wire logic                        bus_wr,
    input  wire logic [`T1IRQ_PAGE_W-1:0]    bus_page,
    input  wire logic [`T1IRQ_ADDR_W-1:0]    bus_addr,
    input  wire t1irq_pkg::t1irq_byte_t      bus_wdata,
    output t1irq_pkg::t1irq_byte_t           bus_rdata,
    // Interrupt control
    input  wire logic                        irq_acknowledge,
    input  wire logic                        irq_suspend,
    output logic                             irq_n_out,
    output logic                             irq_n_oe,
    // Framer and alarm events
    input  wire logic                        terminal_frame_sync,
    input  wire logic                        framing_bit_error,
    input  wire logic                        crc6_error,
    input  wire logic                        yellow_alarm,
    input  wire logic                        align_change,
    input  wire logic                        code_violation,
    input  wire logic                        b8zs_violation,
    input  wire logic                        prbs_error,
    input  wire logic                        pulse_density,
    // Error counters, index is the mask bit
    input  wire logic [7:0][CNT_W-1:0]       counter_value,
    // HDLC and link events
    input  wire logic [2:0]                  hdlc_event,
    input  wire logic                        loop_up_present,
    input  wire logic                        loop_down_present,
    input  wire logic                        one_second_status,
    input  wire logic                        five_second_status,
    input  wire logic                        bom_strobe,
    input  wire logic [`T1IRQ_BOM_W-1:0]     bom_word,
    input  wire logic [3:0]                  sig_bits,
    input  wire logic                        sig_abcd_mode,
    input  wire logic                        signaling_debounce_en,
    // Line data in framer-only mode
    input  wire logic                        liu_disabled,
    input  wire logic                        line_in_a,
    input  wire logic                        line_in_b,
    input  wire logic                        tx_pos,
    input  wire logic                        tx_neg,
    input  wire logic                        tx_nrz,
    output logic                             rx_pos,
    output logic                             rx_neg,
    output logic                             line_out_a,
    output logic                             line_out_b,
    // Receiver analog controls
    output logic                             termination_en,
    output logic                             eq_auto_en,
    output logic                             eq_manual_en,
    output logic [2:0]                       equalizer_level,
    output t1irq_pkg::t1irq_eq_mode_t        eq_mode
);
    import t1irq_pkg::*;

    t1irq_byte_t     framer_alarm_irq_mask;
    t1irq_byte_t     error_event_irq_mask;
    t1irq_byte_t     counter_overflow_irq_mask;
    t1irq_byte_t     link_timer_irq_mask;
    t1irq_byte_t     line_receiver_config;
    t1irq_byte_t     pend_alarm;
    t1irq_byte_t     pend_wrap;
    t1irq_byte_t     pend_link;
    t1irq_byte_t     next_pend_alarm;
    t1irq_byte_t     next_pend_wrap;
    t1irq_byte_t     next_pend_link;
    t1irq_byte_t     ev_alarm;
    t1irq_byte_t     ev_wrap;
    t1irq_byte_t     ev_link;
    logic            bus_sel;
    logic            one_sec_prev;
    logic            five_sec_prev;
    logic            loop_code_up;
    logic            loop_running;
    logic [31:0]     loop_count;
    logic            loop_event;
    logic [3:0]      sig_accepted;
    logic [3:0]      sig_candidate;
    logic [31:0]     sig_stable;
    logic            sig_event;
    logic [3:0]      sig_now;
    logic [`T1IRQ_BOM_WINDOW-1:0] bom_hist_ok;
    t1irq_bom_code_t bom_hist_code [`T1IRQ_BOM_WINDOW];
    t1irq_bom_code_t bom_accepted;
    logic            bom_accepted_ok;
    logic            bom_check;
    logic            bom_event;
    logic [4:0]      bom_votes;
    logic [2:0]      sync_a;
    logic [2:0]      sync_b;
    logic [1:0]      aeq_field;

    assign bus_sel = !bus_cs_n && (bus_page == `T1IRQ_PAGE);

    // Register writes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            framer_alarm_irq_mask     <= `T1IRQ_REG_RESET;
            error_event_irq_mask      <= `T1IRQ_REG_RESET;
            counter_overflow_irq_mask <= `T1IRQ_REG_RESET;
            link_timer_irq_mask       <= `T1IRQ_REG_RESET;
            line_receiver_config      <= `T1IRQ_REG_RESET;
        end else if (bus_sel && bus_wr) begin
            unique case (bus_addr)
                `T1IRQ_ADDR_ALARM_MSK: framer_alarm_irq_mask     <= bus_wdata;
                `T1IRQ_ADDR_ERROR_MSK: error_event_irq_mask      <= bus_wdata;
                `T1IRQ_ADDR_WRAP_MSK:  counter_overflow_irq_mask <= bus_wdata;
                `T1IRQ_ADDR_LINK_MSK:  link_timer_irq_mask       <= bus_wdata;
                `T1IRQ_ADDR_RX_CFG:    line_receiver_config      <= bus_wdata;
                default: begin
                end
            endcase
        end
    end

    // Register reads, one cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= `T1IRQ_READ_UNMAPPED;
        end else if (bus_sel && bus_rd) begin
            unique case (bus_addr)
                `T1IRQ_ADDR_ALARM_MSK: bus_rdata <= framer_alarm_irq_mask;
                `T1IRQ_ADDR_ERROR_MSK: begin
                    bus_rdata <= error_event_irq_mask;
                    bus_rdata[`T1IRQ_UNUSED_BIT] <= 1'b0;
                end
                `T1IRQ_ADDR_WRAP_MSK:  bus_rdata <= counter_overflow_irq_mask;
                `T1IRQ_ADDR_LINK_MSK:  bus_rdata <= link_timer_irq_mask;
                `T1IRQ_ADDR_RX_CFG:    bus_rdata <= line_receiver_config;
                default:               bus_rdata <= `T1IRQ_READ_UNMAPPED;
            endcase
        end
    end

    // Framer and alarm sources
    always_comb begin
        ev_alarm = '0;
        ev_alarm[`T1IRQ_FE_BIT]   = framing_bit_error && terminal_frame_sync;
        ev_alarm[`T1IRQ_CRC_BIT]  = crc6_error;
        ev_alarm[`T1IRQ_YEL_BIT]  = yellow_alarm;
        ev_alarm[`T1IRQ_COFA_BIT] = align_change;
        ev_alarm[`T1IRQ_LCV_BIT]  = code_violation && !b8zs_violation;
        ev_alarm[`T1IRQ_PRBS_BIT] = prbs_error;
        ev_alarm[`T1IRQ_PDV_BIT]  = pulse_density;
    end

    // Counter wrap detectors
    genvar gi;
    generate
        for (gi = 0; gi < `T1IRQ_NUM_COUNTERS; gi++) begin : g_wrap
            t1irq_wrap #(
                .W (CNT_W)
            ) u_wrap (
                .clock   (clock),
                .rstn    (rstn),
                .count   (counter_value[gi]),
                .wrapped (ev_wrap[gi])
            );
        end
    endgenerate

    // Timer status edges
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            one_sec_prev  <= 1'b0;
            five_sec_prev <= 1'b0;
        end else begin
            one_sec_prev  <= one_second_status;
            five_sec_prev <= five_second_status;
        end
    end

    // Loop code persistence timer, fires once per continuous run
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loop_code_up <= 1'b0;
            loop_running <= 1'b0;
            loop_count   <= '0;
            loop_event   <= 1'b0;
        end else begin
            loop_event <= 1'b0;
            if (!(loop_up_present || loop_down_present) ||
                (loop_running && (loop_code_up != loop_up_present))) begin
                loop_running <= 1'b0;
                loop_count   <= '0;
            end else if (!loop_running) begin
                loop_running <= 1'b1;
                loop_code_up <= loop_up_present;
                loop_count   <= 32'h0000_0001;
            end else if (loop_count < LOOP_CYCLES) begin
                loop_count <= loop_count + 32'h0000_0001;
                if (loop_count == LOOP_CYCLES - 32'h0000_0001) begin
                    loop_event <= 1'b1;
                end
            end
        end
    end

    // Signaling change detect with optional debounce
    assign sig_now = sig_abcd_mode ? sig_bits : {2'b00, sig_bits[1:0]};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sig_accepted  <= '0;
            sig_candidate <= '0;
            sig_stable    <= '0;
            sig_event     <= 1'b0;
        end else begin
            sig_event     <= 1'b0;
            sig_candidate <= sig_now;
            if (sig_now != sig_candidate) begin
                sig_stable <= '0;
            end else if (sig_stable < DEBOUNCE_CYCLES) begin
                sig_stable <= sig_stable + 32'h0000_0001;
            end
            if (!signaling_debounce_en && (sig_now != sig_accepted)) begin
                sig_accepted <= sig_now;
                sig_event    <= 1'b1;
            end else if (signaling_debounce_en && (sig_candidate != sig_accepted) &&
                         (sig_now == sig_candidate) && (sig_stable >= DEBOUNCE_CYCLES)) begin
                sig_accepted <= sig_candidate;
                sig_event    <= 1'b1;
            end
        end
    end

    // Bit message history of the last positions
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bom_hist_ok <= '0;
            bom_check   <= 1'b0;
            for (int i = 0; i < `T1IRQ_BOM_WINDOW; i++) begin
                bom_hist_code[i] <= '0;
            end
        end else begin
            bom_check <= bom_strobe;
            if (bom_strobe) begin
                bom_hist_ok <= {bom_hist_ok[`T1IRQ_BOM_WINDOW-2:0],
                                (bom_word[`T1IRQ_BOM_W-1:`T1IRQ_BOM_CODE_W+1] == `T1IRQ_BOM_HEAD)
                                && !bom_word[0]};
                bom_hist_code[0] <= bom_word[`T1IRQ_BOM_CODE_W:1];
                for (int i = 1; i < `T1IRQ_BOM_WINDOW; i++) begin
                    bom_hist_code[i] <= bom_hist_code[i-1];
                end
            end
        end
    end

    // Votes for the newest message among the window
    always_comb begin
        bom_votes = '0;
        for (int i = 0; i < `T1IRQ_BOM_WINDOW; i++) begin
            if (bom_hist_ok[i] && (bom_hist_code[i] == bom_hist_code[0])) begin
                bom_votes = bom_votes + 5'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bom_accepted    <= '0;
            bom_accepted_ok <= 1'b0;
            bom_event       <= 1'b0;
        end else begin
            bom_event <= 1'b0;
            if (bom_check && bom_hist_ok[0] && (bom_votes >= `T1IRQ_BOM_ACCEPT) &&
                (!bom_accepted_ok || (bom_hist_code[0] != bom_accepted))) begin
                bom_accepted    <= bom_hist_code[0];
                bom_accepted_ok <= 1'b1;
                bom_event       <= 1'b1;
            end
        end
    end

    // HDLC and link sources
    always_comb begin
        ev_link = '0;
        ev_link[`T1IRQ_HDLC_A_BIT]   = hdlc_event[0];
        ev_link[`T1IRQ_HDLC_B_BIT]   = hdlc_event[1];
        ev_link[`T1IRQ_HDLC_C_BIT]   = hdlc_event[2];
        ev_link[`T1IRQ_LOOP_BIT]     = loop_event;
        ev_link[`T1IRQ_ONE_SEC_BIT]  = one_second_status && !one_sec_prev;
        ev_link[`T1IRQ_FIVE_SEC_BIT] = five_second_status && !five_sec_prev;
        ev_link[`T1IRQ_BIOM_BIT]     = bom_event;
        ev_link[`T1IRQ_SIG_BIT]      = sig_event;
    end

    // Pending state: masks gate only new events, set wins over acknowledge
    always_comb begin
        next_pend_alarm = irq_acknowledge ? '0 : pend_alarm;
        next_pend_wrap  = irq_acknowledge ? '0 : pend_wrap;
        next_pend_link  = irq_acknowledge ? '0 : pend_link;
        if (!irq_suspend) begin
            next_pend_alarm = next_pend_alarm | (ev_alarm & error_event_irq_mask);
            next_pend_wrap  = next_pend_wrap | (ev_wrap & counter_overflow_irq_mask);
            next_pend_link  = next_pend_link | (ev_link & link_timer_irq_mask);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_alarm <= '0;
            pend_wrap  <= '0;
            pend_link  <= '0;
        end else begin
            pend_alarm <= next_pend_alarm;
            pend_wrap  <= next_pend_wrap;
            pend_link  <= next_pend_link;
        end
    end

    // Open-drain request, pulled low while enabled
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= !irq_suspend &&
                         (|{next_pend_alarm, next_pend_wrap, next_pend_link});
        end
    end

    // Line inputs: three stages, accepted when the last two agree
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {sync_a[1:0], line_in_a};
            sync_b <= {sync_b[1:0], line_in_b};
        end
    end

    // Framer-only line format
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_pos     <= 1'b0;
            rx_neg     <= 1'b0;
            line_out_a <= 1'b0;
            line_out_b <= 1'b0;
        end else if (!liu_disabled) begin
            rx_pos     <= 1'b0;
            rx_neg     <= 1'b0;
            line_out_a <= 1'b0;
            line_out_b <= 1'b0;
        end else if (line_receiver_config[`T1IRQ_NRZ_BIT]) begin
            if (sync_a[1] == sync_a[2]) begin
                rx_pos <= sync_a[2];
            end
            rx_neg     <= 1'b0;
            line_out_a <= 1'b0;
            line_out_b <= tx_nrz;
        end else begin
            if (sync_a[1] == sync_a[2]) begin
                rx_pos <= sync_a[2];
            end
            if (sync_b[1] == sync_b[2]) begin
                rx_neg <= sync_b[2];
            end
            line_out_a <= tx_pos;
            line_out_b <= tx_neg;
        end
    end

    // Receiver analog controls
    assign aeq_field = line_receiver_config[`T1IRQ_AEQ_HI:`T1IRQ_AEQ_LO];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            termination_en  <= 1'b0;
            eq_auto_en      <= 1'b0;
            eq_manual_en    <= 1'b1;
            equalizer_level <= `T1IRQ_EQ_OFF;
            eq_mode         <= t1irq_eq_manual;
        end else begin
            termination_en <= line_receiver_config[`T1IRQ_TERM_BIT];
            eq_auto_en     <= (aeq_field == `T1IRQ_AEQ_AUTO);
            eq_manual_en   <= (aeq_field == `T1IRQ_AEQ_MANUAL);
            if (aeq_field == `T1IRQ_AEQ_MANUAL) begin
                equalizer_level <= line_receiver_config[`T1IRQ_EQ_HI:`T1IRQ_EQ_LO];
                eq_mode         <= t1irq_eq_manual;
            end else if (aeq_field == `T1IRQ_AEQ_AUTO) begin
                equalizer_level <= `T1IRQ_EQ_OFF;
                eq_mode         <= t1irq_eq_auto;
            end else begin
                equalizer_level <= `T1IRQ_EQ_OFF;
                eq_mode         <= t1irq_eq_factory;
            end
        end
    end
endmodule

// File: t1irq_defines.svh
// Register offsets, field positions, reset values and timing figures for t1irq
`ifndef T1IRQ_DEFINES_SVH
`define T1IRQ_DEFINES_SVH

`define T1IRQ_PAGE_W          4
`define T1IRQ_PAGE            4'h1
`define T1IRQ_ADDR_W          5
`define T1IRQ_ADDR_ALARM_MSK  5'h1b
`define T1IRQ_ADDR_ERROR_MSK  5'h1c
`define T1IRQ_ADDR_WRAP_MSK   5'h1d
`define T1IRQ_ADDR_LINK_MSK   5'h1e
`define T1IRQ_ADDR_RX_CFG     5'h1f
`define T1IRQ_REG_RESET       8'h00
`define T1IRQ_READ_UNMAPPED   8'h00

`define T1IRQ_FE_BIT          7
`define T1IRQ_CRC_BIT         6
`define T1IRQ_YEL_BIT         5
`define T1IRQ_COFA_BIT        4
`define T1IRQ_LCV_BIT         3
`define T1IRQ_PRBS_BIT        2
`define T1IRQ_PDV_BIT         1
`define T1IRQ_UNUSED_BIT      0

`define T1IRQ_HDLC_A_BIT      7
`define T1IRQ_HDLC_B_BIT      6
`define T1IRQ_HDLC_C_BIT      5
`define T1IRQ_LOOP_BIT        4
`define T1IRQ_ONE_SEC_BIT     3
`define T1IRQ_FIVE_SEC_BIT    2
`define T1IRQ_BIOM_BIT        1
`define T1IRQ_SIG_BIT         0

`define T1IRQ_NRZ_BIT         7
`define T1IRQ_RSVD_BIT        6
`define T1IRQ_TERM_BIT        5
`define T1IRQ_AEQ_HI          4
`define T1IRQ_AEQ_LO          3
`define T1IRQ_EQ_HI           2
`define T1IRQ_EQ_LO           0
`define T1IRQ_AEQ_MANUAL      2'b00
`define T1IRQ_AEQ_AUTO        2'b11
`define T1IRQ_EQ_OFF          3'h0

`define T1IRQ_CNT_FULL        8'hff
`define T1IRQ_CNT_ZERO        8'h00
`define T1IRQ_NUM_COUNTERS    8

`define T1IRQ_LOOP_MS         48
`define T1IRQ_CLK_KHZ         125000
`define T1IRQ_LOOP_CYCLES     (`T1IRQ_LOOP_MS * `T1IRQ_CLK_KHZ)
`define T1IRQ_SIG_DEBOUNCE    16

`define T1IRQ_BOM_HEAD        8'hfe
`define T1IRQ_BOM_W           15
`define T1IRQ_BOM_CODE_W      6
`define T1IRQ_BOM_WINDOW      10
`define T1IRQ_BOM_ACCEPT      8

`endif

// File: t1irq_pkg.sv
// Types shared by the t1irq framer interrupt and receiver configuration block
`include "t1irq_defines.svh"
package t1irq_pkg;
    typedef logic [7:0] t1irq_byte_t;
    typedef logic [`T1IRQ_BOM_CODE_W-1:0] t1irq_bom_code_t;
    typedef enum logic [1:0] {
        t1irq_eq_manual,
        t1irq_eq_auto,
        t1irq_eq_factory
    } t1irq_eq_mode_t;
endpackage

// File: t1irq_wrap.sv
// Detects an error counter wrapping from all ones to zero
`timescale 1ns/10ps
module t1irq_wrap #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rstn,
    // Counter observed
    input  wire logic [W-1:0] count,
    // One-cycle wrap event
    output logic              wrapped
);
    logic [W-1:0] prev_count;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_count <= '0;
        end else begin
            prev_count <= count;
        end
    end

    assign wrapped = (prev_count == {W{1'b1}}) && (count == '0);
endmodule

// File: t1irq_top_properties.sv
// Port-level checks of interrupt request and receiver word outputs
`timescale 1ns/10ps
module t1irq_top_properties
    import t1irq_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   rstn,
    input wire logic                   bus_rd,
    input wire t1irq_pkg::t1irq_byte_t bus_rdata,
    input wire logic                   irq_acknowledge,
    input wire logic                   irq_suspend,
    input wire logic                   irq_n_out,
    input wire logic                   irq_n_oe,
    input wire logic                   crc6_error,
    input wire logic                   eq_auto_en,
    input wire logic                   eq_manual_en,
    input wire logic [2:0]             equalizer_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ack_clears_irq: assert property (irq_acknowledge && !crc6_error |=> !irq_n_oe)
        else $error("request kept after acknowledge");
    a_suspend_holds_off: assert property (irq_suspend && $past(irq_suspend) |-> !irq_n_oe)
        else $error("request driven in suspend");
    a_rise_not_suspended: assert property ($rose(irq_n_oe) |-> !$past(irq_suspend))
        else $error("request rose in suspend");
    a_pending_stands: assert property (irq_n_oe && !irq_acknowledge && !irq_suspend |=> irq_n_oe)
        else $error("pending request lost");
    a_pin_drives_low: assert property (irq_n_out == 1'b0)
        else $error("request pin not low");
    a_eq_modes_excl: assert property (!(eq_auto_en && eq_manual_en))
        else $error("both equalizer modes on");
    a_auto_level_zero: assert property (eq_auto_en |-> equalizer_level == 3'h0)
        else $error("auto mode kept a level");
    a_rdata_holds: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
        else $error("read data moved");
    c_irq_rise: cover property ($rose(irq_n_oe));
    c_ack_pending: cover property (irq_acknowledge && irq_n_oe);
    c_eq_auto: cover property (eq_auto_en);
endmodule
bind t1irq_top t1irq_top_properties u_props (.clock, .rstn, .bus_rd, .bus_rdata,
    .irq_acknowledge, .irq_suspend, .irq_n_out, .irq_n_oe, .crc6_error, .eq_auto_en,
    .eq_manual_en, .equalizer_level);

// File: tb_t1irq_top.sv
// Self-checking bench for interrupt masking and the receiver word
`timescale 1ns/10ps
`include "t1irq_defines.svh"
module tb_t1irq_top;
    import t1irq_pkg::*;
    logic clock = 0, rstn = 0, bus_cs_n = 1, bus_rd = 0, bus_wr = 0, irq_acknowledge = 0;
    logic irq_suspend = 0, terminal_frame_sync = 0, framing_bit_error = 0, crc6_error = 0;
    logic yellow_alarm = 0, align_change = 0, code_violation = 0, b8zs_violation = 0;
    logic prbs_error = 0, pulse_density = 0, loop_up_present = 0, loop_down_present = 0;
    logic one_second_status = 0, five_second_status = 0, bom_strobe = 0, sig_abcd_mode = 0;
    logic signaling_debounce_en = 0, liu_disabled = 0, line_in_a = 0, line_in_b = 0;
    logic tx_pos = 0, tx_neg = 0, tx_nrz = 0, irq_n_out, irq_n_oe, rx_pos, rx_neg;
    logic line_out_a, line_out_b, termination_en, eq_auto_en, eq_manual_en;
    logic [3:0] bus_page = 4'h1, sig_bits = 4'h0;
    logic [4:0] bus_addr = 5'h00;
    logic [2:0] equalizer_level, hdlc_event = 3'h0;
    logic [14:0] bom_word = 15'h0000;
    logic [7:0][7:0] counter_value = '0;
    t1irq_byte_t bus_wdata = 8'h00, bus_rdata;
    t1irq_eq_mode_t eq_mode;
    int fail_count = 0, tests_run = 0;
    t1irq_top #(.LOOP_CYCLES(20), .DEBOUNCE_CYCLES(4)) DUT (.*);
    always #4 clock = ~clock;
    task automatic cyc(int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(t1irq_byte_t got, t1irq_byte_t exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(logic exp);
        chk({7'h0, irq_n_oe}, {7'h0, exp});
    endtask
    task automatic pulse(ref logic s, input logic exp);
        s = 1;
        cyc();
        s = 0;
        chkb(exp);
    endtask
    task automatic wr(logic [4:0] a, t1irq_byte_t d, logic [3:0] pg = 4'h1);
        bus_cs_n = 0; bus_wr = 1; bus_addr = a; bus_wdata = d; bus_page = pg;
        cyc();
        bus_cs_n = 1; bus_wr = 0; bus_page = 4'h1;
        cyc();
    endtask
    task automatic rd(logic [4:0] a, t1irq_byte_t exp);
        bus_cs_n = 0; bus_rd = 1; bus_addr = a;
        cyc();
        bus_cs_n = 1; bus_rd = 0;
        chk(bus_rdata, exp);
        cyc();
    endtask
    task automatic t_regs();
        t1irq_byte_t v[5] = '{8'ha5, 8'h3d, 8'hc3, 8'h96, 8'h21};
        for (int i = 0; i < 5; i++) rd(5'(27 + i), `T1IRQ_REG_RESET);
        for (int i = 0; i < 5; i++) wr(5'(27 + i), v[i]);
        wr(5'h1c, 8'hff, 4'h2);
        wr(5'h00, 8'hff);
        for (int i = 0; i < 5; i++) rd(5'(27 + i), i == 1 ? 8'h3c : v[i]);
        rd(5'h00, `T1IRQ_READ_UNMAPPED);
        $display("t_regs done");
    endtask
    task automatic t_crc();
        wr(5'h1c, 8'h40);
        pulse(prbs_error, 0);
        pulse(crc6_error, 1);
        cyc(3); chkb(1);
        pulse(irq_acknowledge, 0);
        wr(5'h1c, 8'h04);
        pulse(prbs_error, 1);
        wr(5'h1c, 8'h00); chkb(1);
        pulse(irq_acknowledge, 0);
        $display("t_crc done");
    endtask
    task automatic t_frame();
        wr(5'h1c, 8'h88);
        pulse(framing_bit_error, 0);
        terminal_frame_sync = 1; b8zs_violation = 1;
        pulse(code_violation, 0);
        pulse(framing_bit_error, 1);
        pulse(irq_acknowledge, 0);
        b8zs_violation = 0;
        pulse(code_violation, 1);
        pulse(irq_acknowledge, 0);
        $display("t_frame done");
    endtask
    task automatic t_susp();
        wr(5'h1c, 8'h40);
        pulse(crc6_error, 1);
        irq_suspend = 1; cyc(2); chkb(0);
        irq_suspend = 0; cyc(); chkb(1);
        pulse(irq_acknowledge, 0);
        irq_suspend = 1; cyc();
        pulse(crc6_error, 0);
        irq_suspend = 0; cyc(2); chkb(0);
        $display("t_susp done");
    endtask
    task automatic t_wrap();
        wr(5'h1d, 8'h40);
        for (int i = 5; i < 7; i++) begin
            counter_value[i] = `T1IRQ_CNT_FULL; cyc();
            counter_value[i] = `T1IRQ_CNT_ZERO; cyc();
            chkb(i == 6);
        end
        pulse(irq_acknowledge, 0);
        $display("t_wrap done");
    endtask
    task automatic t_timer();
        wr(5'h1e, 8'h08);
        five_second_status = 1; cyc(); chkb(0);
        one_second_status = 1; cyc(); chkb(1);
        pulse(irq_acknowledge, 0);
        cyc(2); chkb(0);
        one_second_status = 0; five_second_status = 0;
        wr(5'h1e, 8'h31);
        hdlc_event = 3'h4; cyc(); hdlc_event = 3'h0; chkb(1);
        pulse(irq_acknowledge, 0);
        sig_bits = 4'h1; cyc(2); chkb(1);
        pulse(irq_acknowledge, 0);
        loop_up_present = 1; cyc(20); chkb(0); cyc(); chkb(1);
        pulse(irq_acknowledge, 0);
        $display("t_timer done");
    endtask
    task automatic t_eq();
        wr(5'h1f, 8'h25);
        chk({termination_en, eq_auto_en, eq_manual_en, 2'b0, equalizer_level}, 8'ha5);
        wr(5'h1f, 8'h1d);
        chk({termination_en, eq_auto_en, eq_manual_en, 2'b0, equalizer_level}, 8'h40);
        chk(8'(eq_mode), 8'(t1irq_eq_auto));
        $display("t_eq done");
    endtask
    task automatic t_line();
        liu_disabled = 1; line_in_a = 1; line_in_b = 1; tx_nrz = 1; tx_pos = 1;
        wr(5'h1f, 8'h80); cyc(4);
        chk({4'h0, rx_pos, rx_neg, line_out_a, line_out_b}, 8'h09);
        wr(5'h1f, 8'h00); cyc();
        chk({4'h0, rx_pos, rx_neg, line_out_a, line_out_b}, 8'h0e);
        $display("t_line done");
    endtask
    task automatic final_report();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(10); rstn = 1; cyc();
        t_regs(); t_crc(); t_frame(); t_susp(); t_wrap(); t_timer(); t_eq(); t_line();
        final_report();
    end
endmodule
